// ===== src/lpd_pkg.sv
// constants shared by the link-port dma channel block
package lpd_pkg;
	// channel organisation
	localparam int NUM_CH = 8;
	localparam int NUM_LINKS = 4;
	// word positions inside one transfer_control_block
	localparam logic [1:0] W_INDEX = 2'h0;
	localparam logic [1:0] W_XCS = 2'h1;
	localparam logic [1:0] W_YCS = 2'h2;
	localparam logic [1:0] W_CTRL = 2'h3;
	// byte offsets of the event and activity registers
	localparam logic [7:0] OFF_STATUS = 8'h80;
	localparam logic [7:0] OFF_IEN = 8'h84;
	localparam logic [7:0] OFF_ICLR = 8'h88;
	localparam logic [7:0] OFF_ACTIVE = 8'h8c;
	// control_word field positions
	localparam int CW_KIND_LSB = 0;
	localparam int CW_URGENT = 2;
	localparam int CW_TWO_DIM = 3;
	localparam int CW_SIZE_LSB = 4;
	localparam int CW_INT = 6;
	localparam int CW_PER_REQ = 7;
	localparam int CW_CHAIN = 8;
	localparam int CW_TGT_LSB = 9;
	localparam int CW_PTR_LSB = 12;
	// count and step halves of the x and y words
	localparam int CNT_LSB = 16;
	localparam int STEP_LSB = 0;
	// transfer_kind encodings
	localparam logic [1:0] KIND_INT = 2'h0;
	localparam logic [1:0] KIND_EXT = 2'h1;
	localparam logic [1:0] KIND_LINK = 2'h2;
	// link port data register addresses
	localparam logic [31:0] LINK_ADDR_BASE = 32'h001f04a0;
	// reset value of every control block word
	localparam logic [31:0] TCB_RESET = 32'h0;
endpackage

// ===== src/lpd_link_dma.sv
// link-port dma channels: four receive and four transmit channels with one shared engine
//
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// Function
// - four receive channels drain links, four transmit channels feed links
// - transfer_kind of each control_word selects the path of that channel
// - receive to memory requests internal bus, external target goes to outbound_queue
// - index_address is the address, x word gives count and step, y only in 2D
// - two_dim_mode brings the y count and step into addressing
// - completion interrupt raised after the whole block when enabled
// - hardware paces each word by link request, per_request_mode bit ignored
// - chain_enable loads next block from chain_pointer after completion
// - chain_target names which channel block is reloaded, any channel allowed
// - internal memory to link reads memory then hands data to link
// - external source first issues a read through the outbound_queue
// - returned data enters inbound_queue, bus access then drives link
// - link to link: bus write to receiving link port address
// - urgent_request raises internal bus priority in link to link mode
module lpd_link_dma
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic ib_req,
	output logic ib_urgent,
	output logic ib_we,
	output logic [31:0] ib_addr,
	output logic [31:0] ib_wdata,
	input wire logic ib_gnt,
	input wire logic [31:0] ib_rdata,
	output logic oq_valid,
	output logic oq_we,
	output logic [31:0] oq_addr,
	output logic [31:0] oq_wdata,
	input wire logic oq_ready,
	input wire logic iq_valid,
	input wire logic [31:0] iq_data,
	output logic iq_ready,
	input wire logic [3:0] lrx_valid,
	input wire logic [127:0] lrx_data,
	output logic [3:0] lrx_ready,
	input wire logic [3:0] ltx_ready,
	output logic [3:0] ltx_valid,
	output logic [31:0] ltx_data
);

	typedef enum logic [2:0] {ST_IDLE, ST_PUT, ST_RD, ST_OQ, ST_IQ, ST_IB, ST_STEP, ST_CHAIN} lpd_state_type;

	typedef struct packed {
		logic [31:0][31:0] transfer_control_block;
		logic [7:0][15:0] xload;
		logic [7:0] active;
		logic [7:0] status;
		logic [7:0] ien;
		logic irq;
		logic avs_waitrequest;
		logic [31:0] avs_readdata;
		lpd_state_type st;
		logic [2:0] ch;
		logic [1:0] k;
		logic [31:0] data;
		logic ib_req;
		logic ib_urgent;
		logic ib_we;
		logic [31:0] ib_addr;
		logic [31:0] ib_wdata;
		logic oq_valid;
		logic oq_we;
		logic [31:0] oq_addr;
		logic [31:0] oq_wdata;
		logic iq_ready;
		logic [3:0] lrx_ready;
		logic [3:0] ltx_valid;
		logic [31:0] ltx_data;
	} lpd_regs_type;

	lpd_regs_type s;
	lpd_regs_type next_s;

	// combinational views read by the checks below
	logic done_now;
	logic [31:0] cur_cw;
	logic [1:0] cur_kind;
	logic [2:0] chain_tgt;

	// flat word index of one control block word
	function automatic logic [4:0] widx(input logic [2:0] c, input logic [1:0] w);
		return {c, w};
	endfunction

	// sign extension of a 16-bit step
	function automatic logic [31:0] sx(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction

	// only four links exist on each side
	if (lpd_pkg::NUM_CH != 2 * lpd_pkg::NUM_LINKS)
	begin : g_chk
		$error("channel count must be twice the link count");
	end

	// next-state logic: bus slave, channel scheduler, data mover, chaining
	always_comb
	begin
		logic [7:0] elig;
		logic [7:0] urg;
		logic [2:0] sel;
		logic sel_ok;
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] a;
		logic [31:0] cw;
		logic [31:0] nc;
		logic ext;
		elig = 8'h0;
		urg = 8'h0;
		sel = 3'h0;
		sel_ok = 1'b0;
		x = 32'h0;
		y = 32'h0;
		a = 32'h0;
		nc = 32'h0;
		cw = 32'h0;
		ext = 1'b0;
		next_s = s;
		done_now = 1'b0;
		cw = s.transfer_control_block[widx(s.ch, lpd_pkg::W_CTRL)];
		cur_cw = cw;
		cur_kind = cw[lpd_pkg::CW_KIND_LSB +: 2];
		chain_tgt = cw[lpd_pkg::CW_TGT_LSB +: 3];
		next_s.avs_waitrequest = 1'b1;
		next_s.lrx_ready = 4'h0;
		next_s.ltx_valid = 4'h0;
		next_s.iq_ready = 1'b0;

		// slave: one wait cycle, then the access is taken with waitrequest low
		if ((avs_read || avs_write) && s.avs_waitrequest)
		begin
			next_s.avs_waitrequest = 1'b0;
			case (avs_address)
				lpd_pkg::OFF_STATUS: next_s.avs_readdata = {24'h0, s.status};
				lpd_pkg::OFF_IEN: next_s.avs_readdata = {24'h0, s.ien};
				lpd_pkg::OFF_ACTIVE: next_s.avs_readdata = {24'h0, s.active};
				default: next_s.avs_readdata = avs_address[7] ? 32'h0 : s.transfer_control_block[avs_address[6:2]];
			endcase
		end
		if (avs_write && !s.avs_waitrequest)
		begin
			if (!avs_address[7])
			begin
				next_s.transfer_control_block[avs_address[6:2]] = avs_writedata;
				// writing the control word starts the channel
				if (avs_address[3:2] == lpd_pkg::W_CTRL)
				begin
					next_s.active[avs_address[6:4]] = 1'b1;
					next_s.xload[avs_address[6:4]] = s.transfer_control_block[{avs_address[6:4], lpd_pkg::W_XCS}][31:16];
				end
			end
			else if (avs_address == lpd_pkg::OFF_IEN)
				next_s.ien = avs_writedata[7:0];
			else if (avs_address == lpd_pkg::OFF_ICLR)
				next_s.status = s.status & ~avs_writedata[7:0];
		end

		// a channel is eligible only while its link asks for a word
		elig = s.active & {ltx_ready, lrx_valid};
		for (int i = 0; i < 8; i++)
			urg[i] = s.transfer_control_block[widx(3'(i), lpd_pkg::W_CTRL)][lpd_pkg::CW_URGENT];
		for (int i = 7; i >= 0; i--)
		begin
			if (elig[i])
			begin
				sel = 3'(i);
				sel_ok = 1'b1;
			end
		end
		// urgent channels win the scheduler, lowest index first
		for (int i = 7; i >= 0; i--)
		begin
			if (elig[i] && urg[i])
				sel = 3'(i);
		end

		x = s.transfer_control_block[widx(s.ch, lpd_pkg::W_XCS)];
		y = s.transfer_control_block[widx(s.ch, lpd_pkg::W_YCS)];
		a = s.transfer_control_block[widx(s.ch, lpd_pkg::W_INDEX)];
		ext = cur_kind == lpd_pkg::KIND_EXT;

		unique case (s.st)
			ST_IDLE:
			begin
				if (sel_ok)
				begin
					next_s.ch = sel;
					nc = s.transfer_control_block[widx(sel, lpd_pkg::W_CTRL)];
					if (!sel[2])
					begin
						// receive: take the word now, release the link next cycle
						next_s.data = lrx_data[{sel[1:0], 5'h0} +: 32];
						next_s.lrx_ready[sel[1:0]] = 1'b1;
						next_s.st = ST_PUT;
					end
					else if (nc[lpd_pkg::CW_KIND_LSB +: 2] == lpd_pkg::KIND_EXT)
						next_s.st = ST_OQ;
					else
						next_s.st = ST_RD;
				end
			end
			ST_PUT:
			begin
				if (ext ? oq_ready : ib_gnt)
					next_s.st = ST_STEP;
			end
			ST_RD:
			begin
				if (ib_gnt)
				begin
					next_s.data = ib_rdata;
					next_s.ltx_data = ib_rdata;
					next_s.ltx_valid[s.ch[1:0]] = 1'b1;
					next_s.st = ST_STEP;
				end
			end
			ST_OQ:
			begin
				if (oq_ready)
					next_s.st = ST_IQ;
			end
			ST_IQ:
			begin
				if (iq_valid)
				begin
					next_s.data = iq_data;
					next_s.iq_ready = 1'b1;
					next_s.st = ST_IB;
				end
			end
			ST_IB:
			begin
				if (ib_gnt)
				begin
					next_s.ltx_data = s.data;
					next_s.ltx_valid[s.ch[1:0]] = 1'b1;
					next_s.st = ST_STEP;
				end
			end
			ST_STEP:
			begin
				// a count of zero moves one word, like a count of one
				if (x[31:16] > 16'h1)
				begin
					next_s.transfer_control_block[widx(s.ch, lpd_pkg::W_XCS)] = {x[31:16] - 16'h1, x[15:0]};
					next_s.transfer_control_block[widx(s.ch, lpd_pkg::W_INDEX)] = a + sx(x[15:0]);
					next_s.st = ST_IDLE;
				end
				else if (cw[lpd_pkg::CW_TWO_DIM] && y[31:16] > 16'h1)
				begin
					// new row: reload x count, step by the y modifier
					next_s.transfer_control_block[widx(s.ch, lpd_pkg::W_YCS)] = {y[31:16] - 16'h1, y[15:0]};
					next_s.transfer_control_block[widx(s.ch, lpd_pkg::W_XCS)] = {s.xload[s.ch], x[15:0]};
					next_s.transfer_control_block[widx(s.ch, lpd_pkg::W_INDEX)] = a + sx(y[15:0]);
					next_s.st = ST_IDLE;
				end
				else
				begin
					done_now = 1'b1;
					next_s.active[s.ch] = 1'b0;
					// set after the software clear above, so the event is never lost
					if (cw[lpd_pkg::CW_INT])
						next_s.status[s.ch] = 1'b1;
					next_s.k = 2'h0;
					next_s.st = cw[lpd_pkg::CW_CHAIN] ? ST_CHAIN : ST_IDLE;
				end
			end
			ST_CHAIN:
			begin
				if (ib_gnt)
				begin
					next_s.transfer_control_block[widx(chain_tgt, s.k)] = ib_rdata;
					next_s.k = s.k + 2'h1;
					if (s.k == lpd_pkg::W_CTRL)
					begin
						next_s.active[chain_tgt] = 1'b1;
						next_s.xload[chain_tgt] = s.transfer_control_block[widx(chain_tgt, lpd_pkg::W_XCS)][31:16];
						next_s.st = ST_IDLE;
					end
				end
			end
		endcase

		// bus and queue requests follow the state being entered
		nc = next_s.transfer_control_block[widx(next_s.ch, lpd_pkg::W_CTRL)];
		ext = nc[lpd_pkg::CW_KIND_LSB +: 2] == lpd_pkg::KIND_EXT;
		next_s.ib_req = (next_s.st == ST_PUT && !ext) || next_s.st == ST_RD || next_s.st == ST_IB
			|| next_s.st == ST_CHAIN;
		next_s.ib_we = next_s.st == ST_PUT || next_s.st == ST_IB;
		next_s.ib_urgent = nc[lpd_pkg::CW_URGENT];
		if (next_s.st == ST_CHAIN)
			next_s.ib_addr = {8'h0, nc[31:lpd_pkg::CW_PTR_LSB], next_s.k, 2'h0};
		else if (next_s.st == ST_IB)
			next_s.ib_addr = lpd_pkg::LINK_ADDR_BASE + {27'h0, next_s.ch[1:0], 3'h0};
		else
			next_s.ib_addr = next_s.transfer_control_block[widx(next_s.ch, lpd_pkg::W_INDEX)];
		next_s.ib_wdata = next_s.data;
		next_s.oq_valid = (next_s.st == ST_PUT && ext) || next_s.st == ST_OQ;
		next_s.oq_we = next_s.st == ST_PUT;
		next_s.oq_addr = next_s.transfer_control_block[widx(next_s.ch, lpd_pkg::W_INDEX)];
		next_s.oq_wdata = next_s.data;
		next_s.irq = |(next_s.status & next_s.ien);
	end

	// state register
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.avs_waitrequest <= 1'b1;
		end
		else
			s <= next_s;
	end

	// every output straight from the state register
	assign avs_readdata = s.avs_readdata;
	assign avs_waitrequest = s.avs_waitrequest;
	assign irq = s.irq;
	assign ib_req = s.ib_req;
	assign ib_urgent = s.ib_urgent;
	assign ib_we = s.ib_we;
	assign ib_addr = s.ib_addr;
	assign ib_wdata = s.ib_wdata;
	assign oq_valid = s.oq_valid;
	assign oq_we = s.oq_we;
	assign oq_addr = s.oq_addr;
	assign oq_wdata = s.oq_wdata;
	assign iq_ready = s.iq_ready;
	assign lrx_ready = s.lrx_ready;
	assign ltx_valid = s.ltx_valid;
	assign ltx_data = s.ltx_data;

	// checks on the engine
	AST_IRQ: assert property (@(posedge clk) disable iff (!nrst) |(s.status & s.ien) |-> irq)
		else $error("enabled status bit without interrupt");
	AST_URGENT: assert property (@(posedge clk) disable iff (!nrst) ib_req |-> ib_urgent == cur_cw[2])
		else $error("bus priority differs from urgent_request");
	AST_LRX: assert property (@(posedge clk) disable iff (!nrst)
		|lrx_ready |-> ((lrx_ready & ~$past(lrx_valid)) == 4'h0) ##1 (lrx_ready == 4'h0))
		else $error("link released without a request");
	AST_DONE: assert property (@(posedge clk) disable iff (!nrst)
		done_now && cur_cw[6] |=> s.status[s.ch] && !s.active[s.ch])
		else $error("completion did not raise status");
	AST_CHAIN: assert property (@(posedge clk) disable iff (!nrst) done_now && cur_cw[8] |=> ib_req && !ib_we)
		else $error("chain load did not start");
	AST_CHAIN_TGT: assert property (@(posedge clk) disable iff (!nrst)
		s.st == ST_CHAIN && ib_gnt && s.k == 2'h3 |=> s.active[$past(chain_tgt)])
		else $error("chain target not started");
	AST_EXT_RX: assert property (@(posedge clk) disable iff (!nrst)
		s.st == ST_PUT && cur_kind == lpd_pkg::KIND_EXT |-> oq_valid && oq_we && !ib_req)
		else $error("external receive not routed to outbound queue");
	AST_TX_SEND: assert property (@(posedge clk) disable iff (!nrst) |ltx_valid |-> $past(ib_gnt) ##1 !(|ltx_valid))
		else $error("link word sent without bus grant");
	AST_IQ: assert property (@(posedge clk) disable iff (!nrst) iq_ready |-> ib_req && ib_we ##[0:1000] !ib_req)
		else $error("inbound word not driven over bus");

endmodule

// ===== testbench/lpd_bus_model.sv
// internal bus and external-port queue model facing the dma engine
`timescale 1ns/1ps
module lpd_bus_model
#(
	parameter int GNT_DELAY = 2
)
(
	input wire logic clk,
	input wire logic ib_req,
	input wire logic ib_we,
	input wire logic [31:0] ib_addr,
	input wire logic [31:0] ib_wdata,
	output logic ib_gnt,
	output logic [31:0] ib_rdata,
	input wire logic oq_valid,
	input wire logic oq_we,
	input wire logic [31:0] oq_addr,
	input wire logic [31:0] oq_wdata,
	output logic oq_ready,
	output logic iq_valid,
	output logic [31:0] iq_data,
	input wire logic iq_ready
);
	logic [31:0] mem [int];
	logic [31:0] ext [int];
	logic [31:0] iq_q [$];
	logic [31:0] junk = 32'h0;
	int wait_n = 0;
	// data lines only mean something while answered; otherwise they hold a fixed filler (0, all ones on iq_data) so stale values never pass
	assign ib_rdata = (ib_gnt && mem.exists(ib_addr)) ? mem[ib_addr] : junk;
	assign iq_valid = (iq_q.size() != 0);
	assign iq_data = iq_valid ? iq_q[0] : ~junk;
	// slow grant, one-cycle acceptance pulses, outbound-queue read data returned through the inbound queue
	always @(posedge clk)
	begin
		junk <= ~junk + 32'h1;
		ib_gnt <= 1'b0;
		oq_ready <= 1'b0;
		if (ib_req && !ib_gnt)
		begin
			wait_n <= (wait_n >= GNT_DELAY) ? 0 : wait_n + 1;
			ib_gnt <= (wait_n >= GNT_DELAY);
		end
		if (ib_req && ib_gnt && ib_we)
			mem[ib_addr] = ib_wdata;
		if (oq_valid && !oq_ready)
			oq_ready <= 1'b1;
		if (oq_valid && oq_ready && oq_we)
			ext[oq_addr] = oq_wdata;
		if (oq_valid && oq_ready && !oq_we)
			iq_q.push_back(ext[oq_addr]);
		if (iq_ready && iq_valid)
			void'(iq_q.pop_front());
	end
endmodule

// ===== testbench/link_port_dma_channels_test.sv
// self-checking bench for the link-port dma channel block
`timescale 1ns/1ps
module link_port_dma_channels_test;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] avs_address = 8'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] lrx_valid = 4'h0;
	logic [3:0] ltx_ready = 4'h0;
	logic [127:0] lrx_data = 128'h0;
	logic avs_waitrequest, irq, ib_req, ib_urgent, ib_we, ib_gnt, oq_valid, oq_we, oq_ready, iq_valid, iq_ready;
	logic [31:0] avs_readdata, ib_addr, ib_wdata, ib_rdata, oq_addr, oq_wdata, iq_data, ltx_data, rd;
	logic [3:0] lrx_ready, ltx_valid;
	logic [31:0] tx_got [$];
	logic saw_urgent = 1'b0;
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	lpd_link_dma i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .ib_req(ib_req), .ib_urgent(ib_urgent), .ib_we(ib_we),
		.ib_addr(ib_addr), .ib_wdata(ib_wdata), .ib_gnt(ib_gnt), .ib_rdata(ib_rdata), .oq_valid(oq_valid),
		.oq_we(oq_we), .oq_addr(oq_addr), .oq_wdata(oq_wdata), .oq_ready(oq_ready), .iq_valid(iq_valid),
		.iq_data(iq_data), .iq_ready(iq_ready), .lrx_valid(lrx_valid), .lrx_data(lrx_data),
		.lrx_ready(lrx_ready), .ltx_ready(ltx_ready), .ltx_valid(ltx_valid), .ltx_data(ltx_data));
	lpd_bus_model i_bus (.clk(clk), .ib_req(ib_req), .ib_we(ib_we), .ib_addr(ib_addr), .ib_wdata(ib_wdata),
		.ib_gnt(ib_gnt), .ib_rdata(ib_rdata), .oq_valid(oq_valid), .oq_we(oq_we), .oq_addr(oq_addr),
		.oq_wdata(oq_wdata), .oq_ready(oq_ready), .iq_valid(iq_valid), .iq_data(iq_data), .iq_ready(iq_ready));
	// watch transmit words and urgent requests; cut a hang short
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (ltx_valid != 4'h0)
			tx_got.push_back(ltx_data);
		if (ib_req && ib_urgent && ib_we && ib_addr == 32'h001f04a8)
			saw_urgent <= 1'b1;
		if (cycles == 20000)
		begin
			num_errors++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon access; the request holds until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// control word goes last because writing it starts the channel
	task automatic transfer_control_block(input int c, input logic [31:0] i, input logic [31:0] x, input logic [31:0] y,
		input logic [31:0] w);
		bus(1'b1, 8'(c * 16), i);
		bus(1'b1, 8'(c * 16 + 4), x);
		bus(1'b1, 8'(c * 16 + 8), y);
		bus(1'b1, 8'(c * 16 + 12), w);
	endtask
	// offer one word on a receive link; after it is taken the lane shows garbage
	task automatic rx(input int l, input logic [31:0] d);
		// one edge between offers so a release and the next offer never share a time step
		@(posedge clk);
		lrx_data[32 * l +: 32] <= d;
		lrx_valid[l] <= 1'b1;
		do @(posedge clk); while (lrx_ready[l] !== 1'b1);
		lrx_valid[l] <= 1'b0;
		lrx_data[32 * l +: 32] <= ~d;
	endtask
	task automatic idle();
		do bus(1'b0, 8'h8c, 32'h0); while (rd !== 32'h0);
	endtask
	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rchk(8'h80, 32'h0);
		rchk(8'h8c, 32'h0);
		rchk(8'h0c, 32'h0);
		bus(1'b1, 8'h94, 32'hffffffff);
		rchk(8'h94, 32'h0);
		$display("reset test done");
		// receive to internal memory, y word set but two-dim off, per-request bit set
		transfer_control_block(0, 32'h100, 32'h00020004, 32'h00050040, 32'h000000f0);
		rx(0, 32'ha1a1a1a1);
		rx(0, 32'hb2b2b2b2);
		idle();
		chk(i_bus.mem[32'h100], 32'ha1a1a1a1);
		chk(i_bus.mem[32'h104], 32'hb2b2b2b2);
		rchk(8'h80, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h84, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 8'h88, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rchk(8'h80, 32'h0);
		$display("receive internal test done");
		// receive to external memory through the outbound queue, two rows of one word
		transfer_control_block(1, 32'h200, 32'h00010004, 32'h00020010, 32'h00000039);
		rx(1, 32'hc3c3c3c3);
		rx(1, 32'hd4d4d4d4);
		idle();
		chk(i_bus.ext[32'h200], 32'hc3c3c3c3);
		chk(i_bus.ext[32'h210], 32'hd4d4d4d4);
		$display("receive external test done");
		// link to link with urgent priority
		transfer_control_block(2, 32'h001f04a8, 32'h00020000, 32'h0, 32'h00000036);
		rx(2, 32'he5e5e5e5);
		rx(2, 32'hf6f6f6f6);
		idle();
		chk(i_bus.mem[32'h001f04a8], 32'hf6f6f6f6);
		chk({31'h0, saw_urgent}, 32'h1);
		$display("link to link test done");
		// transmit from internal memory, then chain into channel 5 reading external memory
		i_bus.mem[32'h300] = 32'h11111111;
		i_bus.mem[32'h500] = 32'h400;
		i_bus.mem[32'h504] = 32'h00010004;
		i_bus.mem[32'h508] = 32'h0;
		i_bus.mem[32'h50c] = 32'h00000031;
		i_bus.ext[32'h400] = 32'h22222222;
		ltx_ready <= 4'h3;
		transfer_control_block(4, 32'h300, 32'h00010004, 32'h0, 32'h00050b70);
		while (tx_got.size() < 2)
			@(posedge clk);
		idle();
		chk(tx_got[0], 32'h11111111);
		chk(tx_got[1], 32'h22222222);
		rchk(8'h80, 32'h00000010);
		$display("transmit chain test done");
		finish_test();
	end
endmodule
